// >>> mce_pkg.sv
/*
 * Shared constants and types of the move-and-edit engine: character codes,
 * character and memory command carriers, instruction forms and engine states.
 * Assumes a 6-bit character memory with one word-mark bit per location, where
 * lower addresses hold higher-order characters.
 */
// Operation
// - Source characters are taken one at a time, rightmost first, moving left.
// - Each control-word blank takes the next source character, right to left.
// - Without zero suppression the edit ends at the result-field word mark.
// - A control zero is replaced by data and starts a left-to-right suppression scan.
// - Suppression stops at a digit 1-9, a decimal point or the suppression location.
// - Asterisk left of the suppression zero fills zeros, commas and blanks with asterisks.
// - Dollar left of the suppression zero takes data, then floats left of significance.
// - Positive sign blanks credit and minus codes; halts at zero or blank, resumes later.
// - Negative sign keeps credit and minus; moved source characters are never sign-blanked.
// - Control character octal 37 becomes a blank.
// - Decimal points and ordinary control characters stay where written.
// - Commas left of the highest moved source character become blanks.
// - Source fetching stops at the source-field word mark.
// - The result-field word mark is cleared once it ends the edit.
// - Suppression location gets a word mark, cleared and ending the scan when met.
// - The units source character loses its zone bits when stored.
// - Variant state is undefined afterwards; programs must not chain on it.
// - Short forms take the result address, or both addresses, from the registers.
package mae_pkg;

	localparam int ADDR_W = 15;

	// Character codes, six bits each
	localparam logic [5:0] CH_ZERO    = 6'h00;
	localparam logic [5:0] CH_NINE    = 6'h09;
	localparam logic [5:0] CH_BLANK   = 6'h0d;
	localparam logic [5:0] CH_POINT   = 6'h1b;
	localparam logic [5:0] CH_COMMA   = 6'h3b;
	localparam logic [5:0] CH_AST     = 6'h2c;
	localparam logic [5:0] CH_DOLLAR  = 6'h2b;
	localparam logic [5:0] CH_CRED_C  = 6'h13;
	localparam logic [5:0] CH_CRED_R  = 6'h29;
	localparam logic [5:0] CH_CREDIT  = 6'h3d;
	localparam logic [5:0] CH_MINUS   = 6'h20;
	localparam logic [5:0] CH_OCT37   = 6'h1f;

	// Zone field position and the negative-sign zone of the units character
	localparam int         ZONE_HI  = 5;
	localparam int         ZONE_LO  = 4;
	localparam logic [1:0] ZONE_NEG = 2'h2;

	// Instruction forms: full, result address from register, both from registers
	typedef enum logic [1:0] {
		FORM_FULL,
		FORM_B_REG,
		FORM_BOTH_REG
	} mae_form_type;

	// One memory location
	typedef struct packed {
		logic       wm;
		logic [5:0] ch;
	} mae_char_type;

	// One memory access
	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		mae_char_type      data;
	} mae_cmd_type;

	// Meaning of a control-word character
	typedef struct packed {
		logic blank;
		logic zero;
		logic sig;
		logic point;
		logic comma;
		logic sign;
		logic oct37;
		logic ast;
		logic dollar;
	} mae_class_type;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SIGN,
		ST_BRD,
		ST_BDEC,
		ST_ARD,
		ST_BWR,
		ST_SRD,
		ST_SDEC,
		ST_SWR,
		ST_DRD,
		ST_DWR
	} mae_state_type;

endpackage : mae_pkg

// >>> mce_char_class.sv
/*
 * Combinational decoder that sorts one control-word character into its
 * editing meaning. Assumes the character codes of the package.
 */
module mae_char_class
	import mae_pkg::*;
(
	// Character in
	input  wire logic [5:0]    i_ch,
	// Meaning out
	output mae_class_type      o_cls
);

	// Pure decode, no state
	always_comb begin
		o_cls        = '0;
		o_cls.blank  = (i_ch == CH_BLANK);
		o_cls.zero   = (i_ch == CH_ZERO);
		o_cls.sig    = (i_ch != CH_ZERO) && (i_ch <= CH_NINE);
		o_cls.point  = (i_ch == CH_POINT);
		o_cls.comma  = (i_ch == CH_COMMA);
		o_cls.sign   = (i_ch == CH_CRED_C) || (i_ch == CH_CRED_R) ||
		               (i_ch == CH_CREDIT) || (i_ch == CH_MINUS);
		o_cls.oct37  = (i_ch == CH_OCT37);
		o_cls.ast    = (i_ch == CH_AST);
		o_cls.dollar = (i_ch == CH_DOLLAR);
	end

endmodule : mae_char_class

// >>> mce_mem_port.sv
/*
 * Single-location memory access port. Takes one command while idle, holds the
 * request until the memory acknowledges, and returns read data as a pulse.
 * Assumes memory presents read data in the acknowledge cycle.
 */
module mae_mem_port
	import mae_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n,
	// Engine side
	input  wire logic              i_cmd_valid,
	input  wire mae_cmd_type       i_cmd,
	output logic                   o_rsp_valid,
	output mae_char_type           o_rsp_data,
	// Memory side
	input  wire logic              i_mem_ack,
	input  wire mae_char_type      i_mem_rdata,
	output logic                   o_mem_req,
	output logic                   o_mem_we,
	output logic [ADDR_W-1:0]      o_mem_addr,
	output mae_char_type           o_mem_wdata
);

	typedef struct packed {
		logic         req;
		mae_cmd_type  cmd;
		logic         rsp_valid;
		mae_char_type rsp_data;
	} mae_port_type;

	mae_port_type port_reg;
	mae_port_type port_next;

	// One access in flight at a time, so each access moves exactly one location
	always_comb begin
		port_next           = port_reg;
		port_next.rsp_valid = 1'b0;
		if (!port_reg.req && i_cmd_valid) begin
			port_next.req = 1'b1;
			port_next.cmd = i_cmd;
		end else if (port_reg.req && i_mem_ack) begin
			port_next.req       = 1'b0;
			port_next.rsp_valid = 1'b1;
			port_next.rsp_data  = i_mem_rdata;
		end
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			port_reg <= '0;
		end else begin
			port_reg <= port_next;
		end
	end

	assign o_mem_req   = port_reg.req;
	assign o_mem_we    = port_reg.cmd.we;
	assign o_mem_addr  = port_reg.cmd.addr;
	assign o_mem_wdata = port_reg.cmd.data;
	assign o_rsp_valid = port_reg.rsp_valid;
	assign o_rsp_data  = port_reg.rsp_data;

endmodule : mae_mem_port

// >>> mce_edit_engine.sv
/*
 * Move-and-edit engine. Moves a source field into a result field that holds
 * an edit control word, applying fill, suppression, sign control and a
 * floating dollar. Assumes a character memory behind a request/acknowledge
 * port and word marks at the high-order end of both fields.
 */
module mae_edit_engine
	import mae_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n,
	// Instruction
	input  wire logic              i_start,
	input  wire mae_form_type      i_form,
	input  wire logic [ADDR_W-1:0] i_a_addr,
	input  wire logic [ADDR_W-1:0] i_b_addr,
	// Memory
	input  wire logic              i_mem_ack,
	input  wire mae_char_type      i_mem_rdata,
	output logic                   o_mem_req,
	output logic                   o_mem_we,
	output logic [ADDR_W-1:0]      o_mem_addr,
	output mae_char_type           o_mem_wdata,
	// Status
	output logic                   o_busy,
	output logic                   o_done,
	output logic                   o_variant_undef,
	output logic [ADDR_W-1:0]      o_src_addr,
	output logic [ADDR_W-1:0]      o_res_addr
);

	typedef struct packed {
		mae_state_type     st;
		logic              pend;
		logic [ADDR_W-1:0] a_ptr;
		logic [ADDR_W-1:0] b_ptr;
		logic [ADDR_W-1:0] stop_ptr;
		mae_char_type      bch;
		logic [5:0]        out;
		logic              neg;
		logic              zs_found;
		logic              mark_zs;
		logic              prev_zs;
		logic              ast;
		logic              dol;
		logic              blank_on;
		logic              src_done;
		logic              first_src;
		logic              stopped;
		logic              busy;
		logic              done;
		logic              var_undef;
		logic              cmd_valid;
		mae_cmd_type       cmd;
	} mae_eng_type;

	mae_eng_type   eng_reg;
	mae_eng_type   eng_next;
	mae_class_type cls;
	logic          rsp_valid;
	mae_char_type  rsp_data;

	// Read command for one location
	function automatic mae_cmd_type mk_rd(input logic [ADDR_W-1:0] addr);
		mae_cmd_type c;
		c      = '0;
		c.addr = addr;
		return c;
	endfunction : mk_rd

	// Write command for one location
	function automatic mae_cmd_type mk_wr(input logic [ADDR_W-1:0] addr,
	                                      input logic wm, input logic [5:0] ch);
		mae_cmd_type c;
		c         = '0;
		c.we      = 1'b1;
		c.addr    = addr;
		c.data.wm = wm;
		c.data.ch = ch;
		return c;
	endfunction : mk_wr

	// Meaning of the control character under edit
	mae_char_class u_class (
		.i_ch  (eng_reg.bch.ch),
		.o_cls (cls)
	);

	// Memory access port
	mae_mem_port u_port (
		.i_clk_sys   (i_clk_sys),
		.i_reset_n   (i_reset_n),
		.i_cmd_valid (eng_reg.cmd_valid),
		.i_cmd       (eng_reg.cmd),
		.o_rsp_valid (rsp_valid),
		.o_rsp_data  (rsp_data),
		.i_mem_ack   (i_mem_ack),
		.i_mem_rdata (i_mem_rdata),
		.o_mem_req   (o_mem_req),
		.o_mem_we    (o_mem_we),
		.o_mem_addr  (o_mem_addr),
		.o_mem_wdata (o_mem_wdata)
	);

	// Sequencer: every memory state issues once, then waits for the answer
	always_comb begin
		eng_next           = eng_reg;
		eng_next.cmd_valid = 1'b0;
		eng_next.done      = 1'b0;
		case (eng_reg.st)
			ST_IDLE: begin
				if (i_start) begin
					eng_next.busy      = 1'b1;
					eng_next.var_undef = 1'b0;
					// Short forms reuse the address registers
					if (i_form != FORM_BOTH_REG) begin
						eng_next.a_ptr = i_a_addr;
					end
					if (i_form == FORM_FULL) begin
						eng_next.b_ptr = i_b_addr;
					end
					eng_next.zs_found  = 1'b0;
					eng_next.mark_zs   = 1'b0;
					eng_next.prev_zs   = 1'b0;
					eng_next.ast       = 1'b0;
					eng_next.dol       = 1'b0;
					eng_next.blank_on  = 1'b1;
					eng_next.src_done  = 1'b0;
					eng_next.first_src = 1'b1;
					eng_next.stopped   = 1'b0;
					eng_next.pend      = 1'b0;
					eng_next.st        = ST_SIGN;
				end
			end
			// The sign must be known before the rightmost credit symbol is met
			ST_SIGN: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_rd(eng_reg.a_ptr);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend = 1'b0;
					eng_next.neg  = (rsp_data.ch[ZONE_HI:ZONE_LO] == ZONE_NEG);
					eng_next.st   = ST_BRD;
				end
			end
			ST_BRD: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_rd(eng_reg.b_ptr);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend = 1'b0;
					eng_next.bch  = rsp_data;
					eng_next.st   = ST_BDEC;
				end
			end
			// Decide what the control character becomes
			ST_BDEC: begin
				eng_next.mark_zs = cls.zero && !eng_reg.zs_found;
				if (eng_next.mark_zs) begin
					eng_next.zs_found = 1'b1;
				end
				if (eng_reg.prev_zs && cls.ast) begin
					eng_next.ast = 1'b1;
				end
				if (eng_reg.prev_zs && cls.dollar) begin
					eng_next.dol = 1'b1;
				end
				eng_next.prev_zs = eng_next.mark_zs;
				// Sign blanking pauses here until the high-order source digit moves
				if ((cls.blank || cls.zero) && !eng_reg.src_done) begin
					eng_next.blank_on = 1'b0;
				end
				eng_next.out = eng_reg.bch.ch;
				if ((cls.blank || cls.zero || (eng_reg.prev_zs && cls.dollar)) &&
				    !eng_reg.src_done) begin
					eng_next.st = ST_ARD;
				end else begin
					// A leftover float position shows nothing
					if (eng_reg.prev_zs && cls.dollar) begin
						eng_next.out = CH_BLANK;
					end else if (cls.oct37) begin
						eng_next.out = CH_BLANK;
					end else if (cls.sign && !eng_reg.neg && eng_reg.blank_on) begin
						eng_next.out = CH_BLANK;
					end else if (cls.comma && eng_reg.src_done) begin
						eng_next.out = CH_BLANK;
					end
					eng_next.st = ST_BWR;
				end
			end
			// Fetch one source character, rightmost first
			ST_ARD: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_rd(eng_reg.a_ptr);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend = 1'b0;
					eng_next.out  = rsp_data.ch;
					if (eng_reg.first_src) begin
						eng_next.out = {2'h0, rsp_data.ch[ZONE_LO-1:0]};
					end
					eng_next.first_src = 1'b0;
					eng_next.a_ptr     = eng_reg.a_ptr - 1'b1;
					if (rsp_data.wm) begin
						eng_next.src_done = 1'b1;
						eng_next.blank_on = 1'b1;
					end
					eng_next.st = ST_BWR;
				end
			end
			// Store the result; the suppression location gets a word mark
			ST_BWR: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_wr(eng_reg.b_ptr,
					                           eng_reg.mark_zs && !eng_reg.bch.wm,
					                           eng_reg.out);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend = 1'b0;
					if (eng_reg.bch.wm) begin
						if (eng_reg.zs_found) begin
							eng_next.st = ST_SRD;
						end else begin
							eng_next.busy      = 1'b0;
							eng_next.done      = 1'b1;
							eng_next.var_undef = 1'b1;
							eng_next.st        = ST_IDLE;
						end
					end else begin
						eng_next.b_ptr = eng_reg.b_ptr - 1'b1;
						eng_next.st    = ST_BRD;
					end
				end
			end
			// Suppression scan runs left to right from the field's high end
			ST_SRD: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_rd(eng_reg.b_ptr);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend = 1'b0;
					eng_next.bch  = rsp_data;
					eng_next.st   = ST_SDEC;
				end
			end
			ST_SDEC: begin
				eng_next.out = eng_reg.bch.ch;
				if (eng_reg.bch.wm) begin
					// Suppression location reached: the write drops its mark
					if (!eng_reg.stopped) begin
						eng_next.stop_ptr = eng_reg.b_ptr;
					end
					eng_next.st = ST_SWR;
				end else if (eng_reg.stopped) begin
					// Walk on untouched only to find and drop the mark
					eng_next.b_ptr = eng_reg.b_ptr + 1'b1;
					eng_next.st    = ST_SRD;
				end else if (cls.sig || cls.point) begin
					eng_next.stopped  = 1'b1;
					eng_next.stop_ptr = eng_reg.b_ptr;
					eng_next.b_ptr    = eng_reg.b_ptr + 1'b1;
					eng_next.st       = ST_SRD;
				end else if (cls.zero || cls.comma || (eng_reg.ast && cls.blank)) begin
					eng_next.out = eng_reg.ast ? CH_AST : CH_BLANK;
					eng_next.st  = ST_SWR;
				end else begin
					eng_next.b_ptr = eng_reg.b_ptr + 1'b1;
					eng_next.st    = ST_SRD;
				end
			end
			ST_SWR: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_wr(eng_reg.b_ptr, 1'b0, eng_reg.out);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend = 1'b0;
					if (!eng_reg.bch.wm) begin
						eng_next.b_ptr = eng_reg.b_ptr + 1'b1;
						eng_next.st    = ST_SRD;
					end else if (eng_reg.dol) begin
						eng_next.b_ptr = eng_reg.stop_ptr;
						eng_next.st    = ST_DRD;
					end else begin
						eng_next.busy      = 1'b0;
						eng_next.done      = 1'b1;
						eng_next.var_undef = 1'b1;
						eng_next.st        = ST_IDLE;
					end
				end
			end
			// Dollar float: search leftward for the first blank
			ST_DRD: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_rd(eng_reg.b_ptr);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend = 1'b0;
					if (rsp_data.ch == CH_BLANK) begin
						eng_next.st = ST_DWR;
					end else begin
						eng_next.b_ptr = eng_reg.b_ptr - 1'b1;
					end
				end
			end
			ST_DWR: begin
				if (!eng_reg.pend) begin
					eng_next.cmd_valid = 1'b1;
					eng_next.cmd       = mk_wr(eng_reg.b_ptr, 1'b0, CH_DOLLAR);
					eng_next.pend      = 1'b1;
				end else if (rsp_valid) begin
					eng_next.pend      = 1'b0;
					eng_next.b_ptr     = eng_reg.b_ptr - 1'b1;
					eng_next.busy      = 1'b0;
					eng_next.done      = 1'b1;
					eng_next.var_undef = 1'b1;
					eng_next.st        = ST_IDLE;
				end
			end
			default: begin
				eng_next    = '0;
				eng_next.st = ST_IDLE;
			end
		endcase
	end

	// State register; a reset mid-edit leaves memory as far as it got
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			eng_reg <= '0;
		end else begin
			eng_reg <= eng_next;
		end
	end

	// Status straight from the state register
	assign o_busy          = eng_reg.busy;
	assign o_done          = eng_reg.done;
	assign o_variant_undef = eng_reg.var_undef;
	assign o_src_addr      = eng_reg.a_ptr;
	assign o_res_addr      = eng_reg.b_ptr;

endmodule : mae_edit_engine

// >>> mce_chk.sv
/*
 * Port checker of the move-and-edit engine.
 * Assumes binding to the engine top; sees only its ports.
 */
module mae_chk
	import mae_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n,
	// Instruction
	input  wire logic              i_start,
	input  wire mae_form_type      i_form,
	input  wire logic [ADDR_W-1:0] i_a_addr,
	// Memory
	input  wire logic              i_mem_ack,
	input  wire logic              o_mem_req,
	input  wire logic              o_mem_we,
	input  wire logic [ADDR_W-1:0] o_mem_addr,
	input  wire mae_char_type      o_mem_wdata,
	// Status
	input  wire logic              o_busy,
	input  wire logic              o_done,
	input  wire logic              o_variant_undef
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	logic [ADDR_W-1:0] a_cap_reg;
	logic              a_ok_reg;

	// Source address given with start; the held-register form is not tracked
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			a_cap_reg <= '0;
			a_ok_reg  <= 1'b0;
		end else if (i_start && !o_busy) begin
			a_cap_reg <= i_a_addr;
			a_ok_reg  <= (i_form != FORM_BOTH_REG);
		end
	end

	property p_req_hold;
		o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_we) && $stable(o_mem_addr)
			&& $stable(o_mem_wdata);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("memory request changed before acknowledge");

	property p_req_drop;
		o_mem_req && i_mem_ack |=> !o_mem_req;
	endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("memory request held after acknowledge");

	property p_req_gap;
		$fell(o_mem_req) |-> ##1 !o_mem_req;
	endproperty
	a_req_gap: assert property (p_req_gap)
		else $error("memory accesses too close");

	property p_quiet;
		!o_busy |-> !o_mem_req;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("memory access while idle");

	property p_busy_rise;
		i_start && !o_busy |=> o_busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("start not taken");

	property p_first_read;
		$rose(o_busy) && a_ok_reg |-> ##[0:4] (o_mem_req && !o_mem_we && o_mem_addr == a_cap_reg);
	endproperty
	a_first_read: assert property (p_first_read)
		else $error("first access is not a read of the source units place");

	property p_done_pulse;
		o_done |-> !o_busy && $past(o_busy) ##1 !o_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done is not a single pulse ending busy");

	property p_var_set;
		o_done |-> o_variant_undef;
	endproperty
	a_var_set: assert property (p_var_set)
		else $error("variant flag not raised at done");

	property p_var_hold;
		o_variant_undef && !i_start |=> o_variant_undef;
	endproperty
	a_var_hold: assert property (p_var_hold)
		else $error("variant flag dropped without start");
endmodule : mae_chk

bind mae_edit_engine mae_chk u_chk (.i_clk_sys, .i_reset_n, .i_start, .i_form, .i_a_addr,
	.i_mem_ack, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_busy, .o_done,
	.o_variant_undef);

// >>> mce_mem_model.sv
/*
 * Behavioural character memory on the far side of the engine's port.
 * Assumes the bench loads and inspects the array directly; 256 places.
 */
module mae_mem_model
	import mae_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n,
	// Access
	input  wire logic              i_req,
	input  wire logic              i_we,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire mae_char_type      i_wdata,
	input  wire logic [1:0]        i_lat,
	output logic                   o_ack,
	output mae_char_type           o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	mae_char_type mem [0:255];
	logic [1:0]   wait_reg;

	// Cycles waited by the pending request
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n)
			wait_reg <= 2'h0;
		else if (!i_req || o_ack)
			wait_reg <= 2'h0;
		else
			wait_reg <= wait_reg + 2'h1;
	end

	// One place per access; stale data is inverted so it never passes as valid
	assign o_ack   = i_req && (wait_reg >= i_lat);
	assign o_rdata = o_ack ? mem[i_addr[7:0]] : ~mem[i_addr[7:0]];

	// Plain always: the bench also loads this array
	always @(posedge i_clk_sys) begin
		if (i_req && o_ack && i_we)
			mem[i_addr[7:0]] <= i_wdata;
	end
endmodule : mae_mem_model

// >>> tb.sv
/*
 * Self-checking bench of the move-and-edit engine with a memory model.
 * Assumes fields right-aligned at fixed places; random data and latency.
 */
module tb
	import mae_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int A_U = 'h40;
	localparam int B_R = 'h80;

	logic              i_clk_sys, i_reset_n, i_start, i_mem_ack, o_mem_req, o_mem_we;
	logic              o_busy, o_done, o_variant_undef;
	mae_form_type      i_form;
	logic [ADDR_W-1:0] i_a_addr, i_b_addr, o_mem_addr, o_src_addr, o_res_addr;
	mae_char_type      i_mem_rdata, o_mem_wdata;
	logic [1:0]        lat;
	logic [31:0]       seed;
	logic [5:0]        dg [8];
	int                n_fail, checked, len, a_hold, b_hold;
	// Cases keep one high-order mark per field and no dollar with asterisk
	string src_s [7] = '{"123", "0045", "0045", "12", "1N", "9P", "00450"};
	string ctl_s [7] = '{"b&b.b", "b,b0.b", "b,b*0.b", "bb-CRK", "bb-CRK", "b,b,b", "bb$0.b"};
	string exp_s [7] = '{"1 2.3", "   4.5", "****4.5", "12    ", "15-CRK", "  9,6", " $45.0"};

	mae_edit_engine DUT (.i_clk_sys, .i_reset_n, .i_start, .i_form, .i_a_addr, .i_b_addr,
		.i_mem_ack, .i_mem_rdata, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_busy,
		.o_done, .o_variant_undef, .o_src_addr, .o_res_addr);
	mae_mem_model u_mem (.i_clk_sys, .i_reset_n, .i_req(o_mem_req), .i_we(o_mem_we),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_lat(lat), .o_ack(i_mem_ack),
		.o_rdata(i_mem_rdata));

	// 125 MHz clock
	always #4 i_clk_sys = ~i_clk_sys;

	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// Letters stand for the special codes; N and P are zoned units digits
	function automatic logic [5:0] code(byte c);
		case (c)
			"b", " ": return CH_BLANK;
			".": return CH_POINT;
			",": return CH_COMMA;
			"*": return CH_AST;
			"$": return CH_DOLLAR;
			"C": return CH_CRED_C;
			"R": return CH_CRED_R;
			"K": return CH_CREDIT;
			"-": return CH_MINUS;
			"&": return CH_OCT37;
			"N": return 6'h25;
			"P": return 6'h16;
			default: return 6'(c - 8'h30);
		endcase
	endfunction : code

	task automatic cmp(string what, logic [ADDR_W-1:0] e, logic [ADDR_W-1:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : cmp

	// Loads a field ending at hi, mark on its leftmost place
	task automatic put(int hi, string s);
		for (int i = 0; i < s.len(); i++)
			u_mem.mem[hi - s.len() + 1 + i] = {i == 0, code(s[i])};
	endtask : put

	// Result places must match with every word mark cleared
	task automatic chk(int hi, string s);
		for (int i = 0; i < s.len(); i++)
			cmp("result", 15'({1'b0, code(s[i])}), 15'(u_mem.mem[hi - s.len() + 1 + i]));
	endtask : chk

	task automatic run(mae_form_type f, int a, int b);
		int n;
		@(negedge i_clk_sys);
		seed     = lfsr(seed);
		lat      = seed[1:0];
		i_start  = 1'b1;
		i_form   = f;
		i_a_addr = ADDR_W'(a);
		i_b_addr = ADDR_W'(b);
		@(negedge i_clk_sys);
		i_start = 1'b0;
		n = 0;
		while (o_done !== 1'b1 && n < 3000) begin
			@(negedge i_clk_sys);
			n++;
		end
		cmp("done", 15'h1, 15'(o_done));
		cmp("variant", 15'h1, 15'(o_variant_undef));
	endtask : run

	task automatic report_and_stop;
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		i_clk_sys = 1'b0;
		i_reset_n = 1'b0;
		i_start   = 1'b0;
		i_form    = FORM_FULL;
		i_a_addr  = '0;
		i_b_addr  = '0;
		lat       = 2'h0;
		seed      = 32'ha48b612d;
		n_fail    = 0;
		checked   = 0;
		for (int i = 0; i < 256; i++)
			u_mem.mem[i] = 7'h09;
		repeat (10) @(negedge i_clk_sys);
		i_reset_n = 1'b1;
		for (int k = 0; k < 7; k++) begin
			put(A_U, src_s[k]);
			put(B_R, ctl_s[k]);
			run(FORM_FULL, A_U, B_R);
			chk(B_R, exp_s[k]);
		end
		cmp("dollar address", 15'(B_R - 5), o_res_addr);
		put(B_R - 5, "bb");
		put(A_U, "78");
		run(FORM_B_REG, A_U, 0);
		chk(B_R - 5, "78");
		// Shortest form: fields placed where the held address registers point,
		// so an engine that took the instruction addresses would miss them
		a_hold = int'(o_src_addr);
		b_hold = int'(o_res_addr);
		put(a_hold, "34");
		put(b_hold, "bb");
		run(FORM_BOTH_REG, 0, 0);
		chk(b_hold, "34");
		// Random plain moves: all-blank control word, random digits and latency
		for (int r = 0; r < 20; r++) begin
			seed = lfsr(seed);
			len  = 2 + int'(seed[2:0]) % 5;
			for (int i = 0; i < len; i++) begin
				seed  = lfsr(seed);
				dg[i] = 6'(seed[7:0] % 8'h0a);
				u_mem.mem[A_U - len + 1 + i] = {i == 0, dg[i]};
				u_mem.mem[B_R - len + 1 + i] = {i == 0, CH_BLANK};
			end
			run(FORM_FULL, A_U, B_R);
			for (int i = 0; i < len; i++)
				cmp("moved", 15'(dg[i]), 15'(u_mem.mem[B_R - len + 1 + i]));
		end
		report_and_stop;
	end

	// Watchdog well beyond the expected run
	initial begin
		#400000;
		n_fail++;
		report_and_stop;
	end
endmodule : tb
